// File: rtl/port_cfg_pkg.sv
// Register addresses, page codes and reset values for the port 2 / port 3 configuration block
package port_cfg_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT2_DRIVE_MODE       = 8'hA6;
  localparam logic [7:0] ADDR_PORT3_DRIVE_MODE       = 8'hAE;
  localparam logic [7:0] ADDR_PORT3_PIN_DATA         = 8'hB0;
  localparam logic [7:0] ADDR_PORT2_CROSSBAR_BYPASS  = 8'hD6;
  localparam logic [7:0] ADDR_PORT2_ANALOG_SELECT    = 8'hF3;
  localparam logic [7:0] ADDR_PORT3_ANALOG_SELECT    = 8'hF4;

  // ---------------------------------------------------------------
  // Paging and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] CONFIG_PAGE                 = 8'h0F;
  localparam int         PORT3_BIT                   = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT2_DRIVE_MODE        = 8'h00;
  localparam logic [7:0] RST_PORT2_CROSSBAR_BYPASS   = 8'h00;
  localparam logic [7:0] RST_PORT2_ANALOG_SELECT     = 8'hFF;
  localparam logic       RST_PORT3_DRIVE_MODE        = 1'b0;
  localparam logic       RST_PORT3_ANALOG_SELECT     = 1'b1;
  localparam logic       RST_PORT3_LATCH             = 1'b1;

endpackage

// File: rtl/port_cfg.sv
// Configuration and data registers for port 2 and the single pin of port 3
`timescale 1ns/1ps

module port_cfg #(
  parameter int P2_WIDTH = 8
) (
  input  wire logic                mclk,            // System clock
  input  wire logic                resetn,          // Synchronous reset, active low
  input  wire logic [7:0]          sfr_page,        // Current register page
  input  wire logic [7:0]          sfr_addr,        // Register byte address
  input  wire logic                sfr_wr,          // Byte write strobe
  input  wire logic [7:0]          sfr_wdata,       // Byte write data
  input  wire logic                sfr_rd,          // Byte read strobe
  input  wire logic                bit_wr,          // Single-bit write strobe
  input  wire logic                bit_wval,        // Single-bit write value
  input  wire logic [7:0]          bit_addr,        // Bit address (byte address + bit index)
  output logic [7:0]               sfr_rdata,       // Read data, valid cycle after sfr_rd
  output logic                     sfr_hit,         // Read was to a decoded register
  input  wire logic                port3_pin_in,    // Raw level on the port 3 pin
  output logic                     port3_out,       // Output latch value toward the pin
  output logic                     port3_push_pull, // Effective push-pull enable
  output logic                     port3_digital,   // Pull-up and receiver enabled
  output logic [P2_WIDTH-1:0]      port2_push_pull, // Effective push-pull enables
  output logic [P2_WIDTH-1:0]      port2_digital,   // Pull-up and receiver enabled
  output logic [P2_WIDTH-1:0]      port2_skip       // Crossbar skip per pin
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [P2_WIDTH-1:0] p2_drive;
    logic [P2_WIDTH-1:0] p2_bypass;
    logic [P2_WIDTH-1:0] p2_analog_sel;
    logic                p3_drive;
    logic                p3_analog_sel;
    logic                p3_latch;
    logic [2:0]          p3_sync;
    logic                p3_level;
    logic [7:0]          rdata;
    logic                hit;
    logic [P2_WIDTH-1:0] p2_pp_out;
    logic [P2_WIDTH-1:0] p2_dig_out;
    logic [P2_WIDTH-1:0] p2_skip_out;
    logic                p3_pp_out;
    logic                p3_dig_out;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // Narrow registers sit in bit 0; upper bits always read as zero
  function automatic logic [7:0] pad_bit(input logic b);
    pad_bit = {7'h00, b};
  endfunction

  function automatic logic [7:0] pad_p2(input logic [P2_WIDTH-1:0] v);
    logic [7:0] tmp;
    tmp = 8'h00;
    tmp[P2_WIDTH-1:0] = v;
    pad_p2 = tmp;
  endfunction

  // Byte and bit accesses share one address for the data register
  function automatic logic is_p3_data(input logic [7:0] a);
    is_p3_data = (a == port_cfg_pkg::ADDR_PORT3_PIN_DATA);
  endfunction

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Page only gates the configuration registers; the data register
  // must stay reachable from code running on any page
  logic cfg_page;
  logic wr_p3_byte;
  logic wr_p3_bit;
  logic rd_p3_data;

  always_comb begin
    cfg_page   = (sfr_page == port_cfg_pkg::CONFIG_PAGE);
    wr_p3_byte = sfr_wr && is_p3_data(sfr_addr);
    wr_p3_bit  = bit_wr && is_p3_data(bit_addr);
    rd_p3_data = sfr_rd && is_p3_data(sfr_addr);

    state_nxt = state_r;

    // -------------------------------------------------------------
    // Writes
    // -------------------------------------------------------------
    if (sfr_wr && cfg_page) begin
      case (sfr_addr)
        port_cfg_pkg::ADDR_PORT2_DRIVE_MODE: begin
          state_nxt.p2_drive = sfr_wdata[P2_WIDTH-1:0];
        end
        port_cfg_pkg::ADDR_PORT2_CROSSBAR_BYPASS: begin
          state_nxt.p2_bypass = sfr_wdata[P2_WIDTH-1:0];
        end
        port_cfg_pkg::ADDR_PORT2_ANALOG_SELECT: begin
          state_nxt.p2_analog_sel = sfr_wdata[P2_WIDTH-1:0];
        end
        // Narrow registers keep bit 0 only; the rest of the byte is dropped
        port_cfg_pkg::ADDR_PORT3_DRIVE_MODE: begin
          state_nxt.p3_drive = sfr_wdata[port_cfg_pkg::PORT3_BIT];
        end
        port_cfg_pkg::ADDR_PORT3_ANALOG_SELECT: begin
          state_nxt.p3_analog_sel = sfr_wdata[port_cfg_pkg::PORT3_BIT];
        end
        default: begin
        end
      endcase
    end
    // Bit write wins over a simultaneous byte write
    if (wr_p3_byte) begin
      state_nxt.p3_latch = sfr_wdata[port_cfg_pkg::PORT3_BIT];
    end
    if (wr_p3_bit) begin
      state_nxt.p3_latch = bit_wval;
    end

    // -------------------------------------------------------------
    // Pin sampling: change counts once stages two and three agree
    // -------------------------------------------------------------
    // First stage may go metastable and is never used as data
    // Agreement of the last two filters a level that flips for one cycle
    state_nxt.p3_sync = {state_r.p3_sync[1:0], port3_pin_in};
    if (state_r.p3_sync[1] == state_r.p3_sync[2]) begin
      state_nxt.p3_level = state_r.p3_sync[2];
    end

    // -------------------------------------------------------------
    // Reads
    // -------------------------------------------------------------
    // Read data is zero whenever no decoded read is under way
    state_nxt.rdata = 8'h00;
    state_nxt.hit   = 1'b0;
    if (rd_p3_data) begin
      // Receiver off in analog mode, so the pin reads low
      state_nxt.rdata = pad_bit(state_r.p3_level && state_r.p3_analog_sel);
      state_nxt.hit   = 1'b1;
    end else if (sfr_rd && cfg_page) begin
      state_nxt.hit = 1'b1;
      case (sfr_addr)
        port_cfg_pkg::ADDR_PORT2_DRIVE_MODE: begin
          state_nxt.rdata = pad_p2(state_r.p2_drive);
        end
        port_cfg_pkg::ADDR_PORT2_CROSSBAR_BYPASS: begin
          state_nxt.rdata = pad_p2(state_r.p2_bypass);
        end
        port_cfg_pkg::ADDR_PORT2_ANALOG_SELECT: begin
          state_nxt.rdata = pad_p2(state_r.p2_analog_sel);
        end
        port_cfg_pkg::ADDR_PORT3_DRIVE_MODE: begin
          state_nxt.rdata = pad_bit(state_r.p3_drive);
        end
        port_cfg_pkg::ADDR_PORT3_ANALOG_SELECT: begin
          state_nxt.rdata = pad_bit(state_r.p3_analog_sel);
        end
        default: begin
          state_nxt.hit = 1'b0;
        end
      endcase
    end

    // -------------------------------------------------------------
    // Pad controls, registered from the new configuration
    // -------------------------------------------------------------
    // Analog pins lose push-pull even while a stale drive bit is set
    state_nxt.p2_pp_out   = state_nxt.p2_drive & state_nxt.p2_analog_sel;
    state_nxt.p2_dig_out  = state_nxt.p2_analog_sel;
    state_nxt.p2_skip_out = state_nxt.p2_bypass;
    state_nxt.p3_pp_out   = state_nxt.p3_drive & state_nxt.p3_analog_sel;
    state_nxt.p3_dig_out  = state_nxt.p3_analog_sel;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // Pin level starts low; data reads settle a few cycles after reset
      state_r               <= '0;
      state_r.p2_drive      <= port_cfg_pkg::RST_PORT2_DRIVE_MODE[P2_WIDTH-1:0];
      state_r.p2_bypass     <= port_cfg_pkg::RST_PORT2_CROSSBAR_BYPASS[P2_WIDTH-1:0];
      state_r.p2_analog_sel <= port_cfg_pkg::RST_PORT2_ANALOG_SELECT[P2_WIDTH-1:0];
      state_r.p3_drive      <= port_cfg_pkg::RST_PORT3_DRIVE_MODE;
      state_r.p3_analog_sel <= port_cfg_pkg::RST_PORT3_ANALOG_SELECT;
      state_r.p3_latch      <= port_cfg_pkg::RST_PORT3_LATCH;
      state_r.p2_dig_out    <= port_cfg_pkg::RST_PORT2_ANALOG_SELECT[P2_WIDTH-1:0];
      state_r.p3_dig_out    <= port_cfg_pkg::RST_PORT3_ANALOG_SELECT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every pad control leaves straight from a flop, so no decode glitch reaches a pin
  assign sfr_rdata       = state_r.rdata;
  assign sfr_hit         = state_r.hit;
  assign port3_out       = state_r.p3_latch;
  assign port3_push_pull = state_r.p3_pp_out;
  assign port3_digital   = state_r.p3_dig_out;
  assign port2_push_pull = state_r.p2_pp_out;
  assign port2_digital   = state_r.p2_dig_out;
  assign port2_skip      = state_r.p2_skip_out;

endmodule

// File: verification/port_cfg_props.sv
// Assertion checker for the port 2 / port 3 configuration block
`timescale 1ns/1ps
module port_cfg_props #(
  parameter int P2_WIDTH = 8
) (
  input wire logic                mclk,            // System clock
  input wire logic                resetn,          // Synchronous reset, active low
  input wire logic                sfr_wr,          // Byte write strobe
  input wire logic                sfr_rd,          // Byte read strobe
  input wire logic                bit_wr,          // Bit write strobe
  input wire logic                bit_wval,        // Bit write value
  input wire logic                sfr_hit,         // Decoded read flag
  input wire logic                port3_pin_in,    // Pin level
  input wire logic                port3_out,       // Output latch
  input wire logic                port3_push_pull, // Port 3 push-pull
  input wire logic                port3_digital,   // Port 3 digital mode
  input wire logic [7:0]          sfr_page,        // Register page
  input wire logic [7:0]          sfr_addr,        // Byte address
  input wire logic [7:0]          sfr_wdata,       // Write data
  input wire logic [7:0]          bit_addr,        // Bit address
  input wire logic [7:0]          sfr_rdata,       // Read data
  input wire logic [P2_WIDTH-1:0] port2_push_pull, // Port 2 push-pull
  input wire logic [P2_WIDTH-1:0] port2_digital,   // Port 2 digital mode
  input wire logic [P2_WIDTH-1:0] port2_skip       // Port 2 crossbar skip
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_reset_values:
    assert property (disable iff (1'b0) !resetn |=> port3_out && port3_digital
      && port2_skip == '0 && port2_push_pull == '0 && port2_digital == '1)
      else $error("reset values wrong");
  a_page_gate_read: assert property (sfr_rd && sfr_page != 8'h0F && sfr_addr != 8'hB0
    |=> !sfr_hit && sfr_rdata == 8'h00) else $error("config read decoded off page");
  a_any_page_hit: assert property (sfr_rd && sfr_addr == 8'hB0 |=> sfr_hit)
    else $error("port 3 data not decoded");
  a_upper_bits_zero: assert property (sfr_rd && sfr_addr inside {8'hAE, 8'hB0, 8'hF4}
    |=> sfr_rdata[7:1] == 7'h00) else $error("unused bits not zero");
  a_drive_gated: assert property ((port2_push_pull & ~port2_digital) == '0
    && !(port3_push_pull && !port3_digital)) else $error("push-pull on analog pin");
  a_bit_write_latch: assert property (bit_wr && bit_addr == 8'hB0
    |=> port3_out == $past(bit_wval)) else $error("bit write missed latch");
  a_byte_write_latch: assert property (sfr_wr && !bit_wr && sfr_addr == 8'hB0
    |=> port3_out == $past(sfr_wdata[0])) else $error("byte write missed latch");
  a_skip_write: assert property (sfr_wr && sfr_page == 8'h0F && sfr_addr == 8'hD6
    |=> port2_skip == $past(sfr_wdata[P2_WIDTH-1:0])) else $error("skip write lost");
  a_analog_read_zero: assert property (sfr_rd && sfr_addr == 8'hB0 && !port3_digital
    |=> sfr_rdata == 8'h00) else $error("analog pin read nonzero");
  cover property (bit_wr && bit_addr == 8'hB0);
  cover property (sfr_rd && sfr_addr == 8'hB0 && !port3_digital);
  cover property (sfr_wr && sfr_page != 8'h0F && sfr_addr == 8'hD6);
endmodule
bind port_cfg port_cfg_props #(.P2_WIDTH(P2_WIDTH)) port_cfg_props_inst (.mclk, .resetn,
  .sfr_wr, .sfr_rd, .bit_wr, .bit_wval, .sfr_hit, .port3_pin_in, .port3_out, .port3_push_pull,
  .port3_digital, .sfr_page, .sfr_addr, .sfr_wdata, .bit_addr, .sfr_rdata, .port2_push_pull,
  .port2_digital, .port2_skip);

// File: verification/pin_model.sv
// Pad-side model of the port 3 pin
`timescale 1ns/1ps
module pin_model (
  input  wire logic mclk,      // Clock
  input  wire logic drv_out,   // Output latch
  input  wire logic push_pull, // Push-pull enable
  input  wire logic digital,   // Pull-up and receiver enable
  input  wire logic ext_low,   // External pull-down
  output logic      pin        // Level seen on the pad
);
  logic wander = 1'b0;
  always @(posedge mclk) wander <= ~wander;
  // Undriven analog pad floats: no level the bench could rely on
  always_comb begin
    if (push_pull) pin = drv_out;
    else if (ext_low || !drv_out) pin = 1'b0;
    else if (digital) pin = 1'b1;
    else pin = wander;
  end
endmodule

// File: verification/tb_port_cfg.sv
// Self-checking testbench for the port 2 / port 3 configuration block
`timescale 1ns/1ps
module tb_port_cfg;
  logic       mclk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wval = 0, ext_low = 0;
  logic [7:0] sfr_page = 0, sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, sfr_rdata;
  logic       sfr_hit, port3_pin_in, port3_out, port3_push_pull, port3_digital;
  logic [7:0] port2_push_pull, port2_digital, port2_skip;
  int         err_total = 0, num_checks = 0;
  port_cfg port_cfg_inst (.mclk, .resetn, .sfr_page, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .bit_wr, .bit_wval, .bit_addr, .sfr_rdata, .sfr_hit, .port3_pin_in, .port3_out,
    .port3_push_pull, .port3_digital, .port2_push_pull, .port2_digital, .port2_skip);
  pin_model pin_model_inst (.mclk, .drv_out(port3_out), .push_pull(port3_push_pull),
    .digital(port3_digital), .ext_low, .pin(port3_pin_in));
  initial forever #50 mclk = ~mclk;
  task automatic chk(input string what, input logic [8:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic b, input logic [7:0] pg, ad, d);
    @(negedge mclk);
    {sfr_page, sfr_addr, bit_addr, sfr_wdata, bit_wval} = {pg, ad, ad, d, d[0]};
    {sfr_wr, bit_wr} = {!b, b};
    @(negedge mclk);
    {sfr_wr, bit_wr} = 2'b00;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] pg, ad, input logic [8:0] exp);
    @(negedge mclk);
    {sfr_page, sfr_addr, sfr_rd} = {pg, ad, 1'b1};
    @(negedge mclk);
    sfr_rd = 0;
    chk("read hit and data", exp, {sfr_hit, sfr_rdata});
  endtask
  task automatic t_reset;
    chk("p3 latch and p2 skip", 9'h100, {port3_out, port2_skip});
    chk("p2 digital", 9'h0FF, port2_digital);
    rd(8'h0F, 8'hF3, 9'h1FF);
    rd(8'h0F, 8'hF4, 9'h101);
    rd(8'h0F, 8'h55, 9'h000);
  endtask
  task automatic t_port2;
    wr(0, 8'h0F, 8'hA6, 8'h5A);
    wr(0, 8'h0F, 8'hF3, 8'hF0);
    chk("p2 push-pull", 9'h050, port2_push_pull);
    chk("p2 digital", 9'h0F0, port2_digital);
    wr(0, 8'h0F, 8'hD6, 8'hAF);
    wr(0, 8'h00, 8'hD6, 8'h00);
    chk("p2 skip", 9'h0AF, port2_skip);
    rd(8'h00, 8'hA6, 9'h000);
  endtask
  task automatic t_port3;
    wr(0, 8'h0F, 8'hAE, 8'hFF);
    rd(8'h0F, 8'hAE, 9'h101);
    wr(1, 8'h00, 8'hB1, 8'h00);
    chk("latch after stray bit write", 9'h001, port3_out);
    wr(1, 8'h00, 8'hB0, 8'h00);
    chk("latch after bit writes", 9'h001, {port3_out, port3_push_pull});
    repeat (8) @(negedge mclk);
    rd(8'h05, 8'hB0, 9'h100);
    wr(0, 8'h0F, 8'hAE, 8'h00);
    wr(0, 8'h00, 8'hB0, 8'hFF);
    chk("latch after byte write", 9'h001, port3_out);
    ext_low = 1;
    repeat (8) @(negedge mclk);
    rd(8'h00, 8'hB0, 9'h100);
    ext_low = 0;
    repeat (8) @(negedge mclk);
    rd(8'h00, 8'hB0, 9'h101);
    wr(0, 8'h0F, 8'hAE, 8'h01);
    wr(0, 8'h0F, 8'hF4, 8'hFE);
    chk("p3 analog pad", 9'h000, {port3_digital, port3_push_pull});
    rd(8'h0F, 8'hF4, 9'h100);
    rd(8'h00, 8'hB0, 9'h100);
  endtask
  task automatic t_mid_reset;
    wr(1, 8'h00, 8'hB0, 8'h00);
    @(negedge mclk);
    resetn = 0;
    repeat (2) @(negedge mclk);
    resetn = 1;
    chk("p3 pads after reset", 9'h006, {port3_out, port3_digital, port3_push_pull});
    chk("p2 skip after reset", 9'h000, port2_skip);
    chk("p2 push-pull after reset", 9'h000, port2_push_pull);
    chk("p2 digital after reset", 9'h0FF, port2_digital);
    rd(8'h0F, 8'hA6, 9'h100);
    rd(8'h0F, 8'hF4, 9'h101);
    repeat (8) @(negedge mclk);
    rd(8'h00, 8'hB0, 9'h101);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    resetn = 1;
    t_reset();
    t_port2();
    t_port3();
    t_mid_reset();
    summarize();
  end
  initial begin
    #400000;
    err_total++;
    summarize();
  end
endmodule
